// ### rtl/flow_node_pkg.sv
// Package of constants and types for the tagged flow pipeline node.
package flow_node_pkg;
    localparam int DATA_W = 32;
    localparam int TAG_W = 4;
    localparam int GROUPS = 4;
    localparam int GATES_PER_GROUP = 128;
    localparam int GATES_PER_VECTOR = 512;
    localparam int RANGES_PER_FILTER = 32;
    localparam int FILTERS_PER_GROUP = 4;
    localparam int ESTIMATES = 3;
    localparam int GATE_W = 9;
    localparam int BEAM_W = 10;
    localparam int AVG_WIN = 4;
    localparam int AVG_SHIFT = 2;
    localparam int POWER_POS = 12;
    localparam int VEL_POS = 4;
    localparam int BW_POS = 0;
    localparam logic [TAG_W-1:0] TAG_CONTROL = 4'hF;
    localparam logic [TAG_W-1:0] TAG_HEAD = 4'hE;
    localparam logic [TAG_W-1:0] TAG_TAIL = 4'hD;
    localparam logic [GATE_W-1:0] GATE_RESET = 9'h000;
    localparam logic [BEAM_W-1:0] BEAM_RESET = 10'h000;
    typedef enum logic [1:0] {KIND_BYPASS, KIND_CONTROL, KIND_FLOW} word_kind_t;
    typedef enum {EMIT_IDLE, EMIT_HEAD, EMIT_BODY, EMIT_TAIL} emit_state_t;
endpackage

// ### rtl/tagged_flow_pipeline_node.sv
// Colour-flow node on the tagged data chain: dispatch, estimation, packing and emission.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Chain data flows one way only: input port to output port downstream.
// [R2] Incoming word processed only when its tag equals the node address.
// [R3] Words with other tags forwarded unchanged downstream.
// [R4] Untagged data bypassed, control tag to master port, flow data to groups.
// [R5] Flow spread over four groups of 128 gates, 512 gates per vector.
// [R6] Dispatcher keeps running beam and range counts.
// [R7] Dispatched data buffered before transfer into the filter stage.
// [R8] Each filter handles 32 ranges: fixed target cancel then autocorrelation.
// [R9] Four filters of a group feed the estimator one after another.
// [R10] Range averaging slides a window: add newest, remove oldest, divide.
// [R11] Velocity and bandwidth from lookup tables, power computed directly.
// [R12] Three estimates of each group pass a buffer to the master.
// [R13] Each gate packed in 16 bits: 4 power, 8 velocity, 4 bandwidth.
// [R14] Packed words form a whole beam sent through an output buffer.
// [R15] Head and tail tag words surround each emitted vector.
// [R16] Upstream sends all pulse sets of a range before the next range.
// [R17] Upstream sends flow data one range gate at a time.
// [R18] Power in top four bits, velocity middle eight, bandwidth low four.
// [R19] Full output buffer stalls emission; bypass traffic still flows in order. Code also holds bypass words (in_ready low) while the buffer is full.
module tagged_flow_pipeline_node
    import flow_node_pkg::*;
#(
    parameter logic [TAG_W-1:0] NODE_ADDR = 4'h3,
    parameter int PULSES = 8
) (
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Upstream chain input.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DATA_W-1:0] in_data,
    // Downstream chain output.
    output logic out_valid,
    input wire logic out_ready,
    output logic [DATA_W-1:0] out_data,
    // Control words toward the master.
    output logic ctrl_valid,
    output logic [DATA_W-1:0] ctrl_data,
    // Lookup tables in external memory, addressed by averaged lag-one terms.
    output logic [7:0] lut_addr,
    input wire logic [7:0] vel_lut,
    input wire logic [3:0] bw_lut,
    // Position of the incoming flow data.
    output logic [BEAM_W-1:0] beam_num,
    output logic [GATE_W-1:0] gate_num
);
    // ************************************************************
    // Classification
    // ************************************************************
    function automatic word_kind_t classify(input logic [DATA_W-1:0] w);
        logic [TAG_W-1:0] t;
        t = w[DATA_W-1 -: TAG_W];
        if (t == NODE_ADDR) begin
            return KIND_FLOW; // [R2]
        end else if (t == TAG_CONTROL) begin
            return KIND_CONTROL; // [R4]
        end
        return KIND_BYPASS; // [R3]
    endfunction

    // ************************************************************
    // Two-entry output buffer
    // ************************************************************
    logic [DATA_W-1:0] buf_mem [0:1];
    logic [1:0] buf_cnt;
    logic buf_wp;
    logic buf_rp;
    logic buf_push;
    logic [DATA_W-1:0] buf_din;
    logic buf_full;
    assign buf_full = (buf_cnt == 2'h2);
    assign out_valid = (buf_cnt != 2'h0); // [R1]
    assign out_data = buf_mem[buf_rp];
    wire buf_pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            buf_cnt <= 2'h0;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
        end else if (clk_en) begin
            if (buf_push) begin
                buf_wp <= ~buf_wp;
            end
            if (buf_pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && buf_push) begin
            buf_mem[buf_wp] <= buf_din;
        end
    end

    // ************************************************************
    // Emission state and arbitration
    // ************************************************************
    emit_state_t emit_state;
    logic [GATE_W:0] emit_cnt;
    logic [15:0] beam_mem [0:GATES_PER_VECTOR-1];
    logic beam_ready;
    word_kind_t in_kind;
    assign in_kind = classify(in_data);

    // Bypass words take priority over emission pushes, so traffic passing through waits only while the buffer is full.
    wire bypass_req = in_valid && (in_kind == KIND_BYPASS);
    wire emit_req = (emit_state != EMIT_IDLE);
    wire emit_go = emit_req && !bypass_req && !buf_full; // [R19]
    assign in_ready = (in_kind == KIND_BYPASS) ? !buf_full : 1'b1; // [R19]
    wire take = in_valid && in_ready;
    assign buf_push = (bypass_req && !buf_full) || emit_go;

    always_comb begin
        buf_din = in_data; // [R3]
        unique case (emit_state)
            EMIT_HEAD: begin
                if (!bypass_req) begin
                    buf_din = {TAG_HEAD, beam_num, {(DATA_W-TAG_W-BEAM_W){1'b0}}}; // [R15]
                end
            end
            EMIT_BODY: begin
                if (!bypass_req) begin
                    buf_din = {NODE_ADDR, 12'h000, beam_mem[emit_cnt[GATE_W-1:0]]}; // [R14]
                end
            end
            EMIT_TAIL: begin
                if (!bypass_req) begin
                    buf_din = {TAG_TAIL, beam_num, {(DATA_W-TAG_W-BEAM_W){1'b0}}}; // [R15]
                end
            end
            EMIT_IDLE: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            emit_state <= EMIT_IDLE;
            emit_cnt <= '0;
        end else if (clk_en) begin
            unique case (emit_state)
                EMIT_IDLE: begin
                    if (beam_ready) begin
                        emit_state <= EMIT_HEAD;
                    end
                end
                EMIT_HEAD: begin
                    if (emit_go) begin
                        emit_state <= EMIT_BODY;
                        emit_cnt <= '0;
                    end
                end
                EMIT_BODY: begin
                    if (emit_go) begin
                        emit_cnt <= emit_cnt + 1'b1;
                        if (emit_cnt == (GATE_W+1)'(GATES_PER_VECTOR-1)) begin
                            emit_state <= EMIT_TAIL;
                        end
                    end
                end
                EMIT_TAIL: begin
                    if (emit_go) begin
                        emit_state <= EMIT_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Control path and position counters
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_valid <= 1'b0;
            ctrl_data <= '0;
        end else if (clk_en) begin
            ctrl_valid <= take && (in_kind == KIND_CONTROL); // [R4]
            if (take && in_kind == KIND_CONTROL) begin
                ctrl_data <= in_data;
            end
        end
    end

    // Pulses of one gate arrive together, so the gate count steps after PULSES words.
    logic [7:0] pulse_cnt;
    wire flow_take = take && (in_kind == KIND_FLOW);
    wire gate_done = flow_take && (pulse_cnt == 8'(PULSES-1)); // [R16]
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pulse_cnt <= 8'h00;
            gate_num <= GATE_RESET;
            beam_num <= BEAM_RESET;
        end else if (clk_en && flow_take) begin
            pulse_cnt <= gate_done ? 8'h00 : pulse_cnt + 8'h01; // [R17]
            if (gate_done) begin
                gate_num <= gate_num + 1'b1; // [R6]
                if (gate_num == GATE_W'(GATES_PER_VECTOR-1)) begin
                    beam_num <= beam_num + 1'b1; // [R6]
                end
            end
        end
    end

    // ************************************************************
    // Filter stage: fixed target cancel and lag-one autocorrelation
    // ************************************************************
    // Group is the top two gate bits, filter the next two, range within filter the low five.
    logic signed [15:0] prev_i, prev_q;
    logic signed [15:0] acc_re, acc_pw;
    logic first_pulse;
    wire signed [15:0] cur_i = in_data[15:0];
    wire signed [15:0] cur_q = 16'(signed'(in_data[27:16]));
    wire signed [15:0] ftc_i = cur_i - prev_i; // [R8]
    wire signed [15:0] ftc_q = cur_q - prev_q; // [R8]
    // The stored value includes the current pulse, so the last lag term of a gate is never lost.
    wire signed [15:0] next_acc_re = first_pulse ? 16'h0000
        : acc_re + 16'((ftc_i * ftc_i + ftc_q * ftc_q) >>> 8); // [R8]
    wire signed [15:0] next_acc_pw = first_pulse ? 16'h0000
        : acc_pw + 16'((ftc_i >>> 4) * (ftc_i >>> 4)); // [R8]
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prev_i <= '0;
            prev_q <= '0;
            acc_re <= '0;
            acc_pw <= '0;
            first_pulse <= 1'b1;
        end else if (clk_en && flow_take) begin
            prev_i <= cur_i;
            prev_q <= cur_q;
            first_pulse <= gate_done;
            acc_re <= next_acc_re; // [R8]
            acc_pw <= next_acc_pw; // [R8]
        end
    end

    // Estimates land in per-group stores, visited by filter then range. [R5] [R7] [R9]
    logic [15:0] gate_re [0:GATES_PER_VECTOR-1];
    logic [15:0] gate_pw [0:GATES_PER_VECTOR-1];
    always_ff @(posedge sys_clk) begin
        if (clk_en && gate_done) begin
            gate_re[gate_num] <= next_acc_re; // [R7]
            gate_pw[gate_num] <= next_acc_pw; // [R9]
        end
    end

    // ************************************************************
    // Estimator: sliding range average and packing
    // ************************************************************
    logic est_run;
    logic [GATE_W:0] est_idx;
    logic [17:0] win_re, win_pw;
    wire [GATE_W-1:0] est_g = est_idx[GATE_W-1:0];
    wire [GATE_W-1:0] old_g = est_g - GATE_W'(AVG_WIN);
    wire old_in = (est_idx >= (GATE_W+1)'(AVG_WIN));
    wire [17:0] next_win_re = win_re + 18'(gate_re[est_g]) - (old_in ? 18'(gate_re[old_g]) : 18'h00000); // [R10]
    wire [17:0] next_win_pw = win_pw + 18'(gate_pw[est_g]) - (old_in ? 18'(gate_pw[old_g]) : 18'h00000); // [R10]
    wire [15:0] avg_re = 16'(next_win_re >> AVG_SHIFT); // [R10]
    wire [15:0] avg_pw = 16'(next_win_pw >> AVG_SHIFT);
    assign lut_addr = avg_re[15:8]; // [R11]
    wire [3:0] power_est = avg_pw[15:12]; // [R11]
    wire est_last = (est_idx == (GATE_W+1)'(GATES_PER_VECTOR-1));

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            est_run <= 1'b0;
            est_idx <= '0;
            win_re <= '0;
            win_pw <= '0;
            beam_ready <= 1'b0;
        end else if (clk_en) begin
            beam_ready <= 1'b0;
            if (!est_run && gate_done && gate_num == GATE_W'(GATES_PER_VECTOR-1)
                && emit_state == EMIT_IDLE) begin
                est_run <= 1'b1;
                est_idx <= '0;
                win_re <= '0;
                win_pw <= '0;
            end else if (est_run) begin
                win_re <= next_win_re;
                win_pw <= next_win_pw;
                est_idx <= est_idx + 1'b1;
                if (est_last) begin
                    est_run <= 1'b0;
                    beam_ready <= 1'b1; // [R12]
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && est_run) begin
            beam_mem[est_g] <= {power_est, vel_lut, bw_lut}; // [R13] [R18]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    bypass_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R3]
        clk_en && in_valid && in_ready && in_kind == KIND_BYPASS |-> buf_push && buf_din == in_data)
        else $error("bypass word not forwarded unchanged");
    flow_absorb_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
        in_valid && in_kind == KIND_FLOW |-> in_ready && !(bypass_req))
        else $error("flow word not absorbed");
    ctrl_route_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R4]
        clk_en && take && in_kind == KIND_CONTROL |=> ctrl_valid && ctrl_data == $past(in_data))
        else $error("control word not routed");
    full_stall_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R19]
        buf_full |-> !buf_push)
        else $error("push into full buffer");
    head_first_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R15]
        clk_en && emit_state == EMIT_HEAD && emit_go |-> buf_din[DATA_W-1 -: TAG_W] == TAG_HEAD)
        else $error("head tag missing");
    tail_last_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R15]
        clk_en && emit_state == EMIT_TAIL && emit_go |=> emit_state == EMIT_IDLE)
        else $error("tail not ending vector");
    gate_step_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
        clk_en && gate_done |=> gate_num == $past(gate_num) + 1'b1)
        else $error("gate count did not step");
    pack_order_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R14]
        clk_en && emit_state == EMIT_BODY && emit_go |-> buf_din[DATA_W-1 -: TAG_W] == NODE_ADDR)
        else $error("body word lost its tag");
    beam_step_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
        clk_en && gate_done && gate_num == GATE_W'(GATES_PER_VECTOR-1) |=> beam_num == $past(beam_num) + 1'b1)
        else $error("beam count did not step after last gate");
    enable_freeze_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
        !clk_en |=> $stable(gate_num) && $stable(buf_cnt) && $stable(emit_state))
        else $error("state moved while clock enable low");
endmodule

`default_nettype wire

// ### verification/flow_sink_model.sv
// Far side model: downstream capture port with stalls, plus the lookup memory.
`timescale 1ns/1ps
`default_nettype none
module flow_sink_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Stall pattern: 0 always ready, 1 stall one cycle in four, 2 full stall.
    input wire logic [1:0] stall_mode,
    // Chain output handshake.
    output logic out_ready,
    // Lookup memory.
    input wire logic [7:0] lut_addr,
    output logic [7:0] vel_lut,
    output logic [3:0] bw_lut
);
    logic [1:0] phase = 2'h0;
    initial out_ready = 1'b0;
    // The capture port only takes words; it never pushes anything back upstream.
    always @(posedge sys_clk) begin
        phase <= phase + 2'h1;
        out_ready <= #2 rstn && (stall_mode == 2'h0 || (stall_mode == 2'h1 && phase != 2'h0));
    end
    // Answers in the same cycle, as a combinational memory would.
    assign vel_lut = lut_addr ^ 8'hA5;
    assign bw_lut = lut_addr[7:4] ^ lut_addr[3:0];
endmodule
`default_nettype wire

// ### verification/tb_tagged_flow_pipeline_node.sv
// Self-checking bench for the tagged flow pipeline node.
`timescale 1ns/1ps
`default_nettype none
module tb_tagged_flow_pipeline_node;
    import flow_node_pkg::*;
    localparam int PULSES = 2;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic in_valid = 1'b0;
    logic [DATA_W-1:0] in_data = 32'h0;
    logic [1:0] stall_mode = 2'h0;
    logic clk_en = 1'b1;
    logic in_ready, out_valid, out_ready, ctrl_valid;
    logic [DATA_W-1:0] out_data, ctrl_data;
    logic [7:0] lut_addr, vel_lut;
    logic [3:0] bw_lut;
    logic [BEAM_W-1:0] beam_num;
    logic [GATE_W-1:0] gate_num;
    logic [15:0] seed = 16'h0018;
    logic [DATA_W-1:0] got[$];
    logic [DATA_W-1:0] exp_q[$];
    int num_errors = 0;
    int tests_run = 0;
    int ctrl_seen = 0;

    tagged_flow_pipeline_node #(.NODE_ADDR(4'h3), .PULSES(PULSES)) u_tagged_flow_pipeline_node (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .ctrl_valid(ctrl_valid), .ctrl_data(ctrl_data),
        .lut_addr(lut_addr), .vel_lut(vel_lut), .bw_lut(bw_lut),
        .beam_num(beam_num), .gate_num(gate_num));
    flow_sink_model u_flow_sink_model (
        .sys_clk(sys_clk), .rstn(rstn), .stall_mode(stall_mode), .out_ready(out_ready),
        .lut_addr(lut_addr), .vel_lut(vel_lut), .bw_lut(bw_lut));

    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
        if (ctrl_valid === 1'b1) ctrl_seen++;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expv);
        tests_run++;
        if (seen !== expv) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, expv);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Valid stays up when it returns, so back-to-back words need no idle cycle.
    task automatic send(input logic [DATA_W-1:0] word);
        int n;
        in_valid = 1'b1;
        in_data = word;
        for (n = 0; n < 2000; n++) begin
            @(negedge sys_clk);
            if (in_ready === 1'b1) break;
        end
        if (n == 2000) begin
            num_errors++;
            report_and_stop();
        end
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle();
        in_valid = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_words(input int n);
        int c;
        for (c = 0; c < 6000 && got.size() < n; c++) begin
            @(posedge sys_clk);
            #1;
        end
        if (got.size() < n) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    // Bandwidth that the far-side table holds for the entry whose velocity is v.
    function automatic logic [3:0] bw_of_vel(input logic [7:0] v);
        logic [7:0] a;
        a = v ^ 8'hA5;
        return a[7:4] ^ a[3:0];
    endfunction
    function automatic logic [DATA_W-1:0] bypass_word(input logic [15:0] s);
        logic [3:0] tag;
        tag = s[3:0];
        if (tag == 4'h3 || tag == 4'hF) tag = tag ^ 4'h1;
        return {tag, s[11:0], s};
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int i;
        int g;
        int moving;
        repeat (4) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        check({31'h0, out_valid}, 32'h0);
        check({31'h0, in_ready}, 32'h1);
        check({22'h0, beam_num}, 32'h0);
        // With the clock enable low an offered word must not enter the node.
        clk_en = 1'b0;
        in_valid = 1'b1;
        in_data = 32'h5000_0005;
        repeat (3) @(posedge sys_clk);
        #1;
        check({31'h0, out_valid}, 32'h0);
        clk_en = 1'b1;
        idle();
        // Bypass traffic, corner tags first, with the receiver stalling.
        stall_mode = 2'h1;
        exp_q.push_back(32'h0000_0000);
        exp_q.push_back(32'hE123_4567);
        for (i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            exp_q.push_back(bypass_word(seed));
        end
        foreach (exp_q[j]) send(exp_q[j]);
        idle();
        wait_words(exp_q.size());
        foreach (exp_q[j]) check(got[j], exp_q[j]);
        got.delete();
        // Fill the buffer, pass a control word meanwhile, then expect refusal.
        stall_mode = 2'h2;
        send(32'h1000_0001);
        send(32'h2000_0002);
        send(32'hF00C_0DE5);
        idle();
        check(ctrl_data, 32'hF00C_0DE5);
        check(ctrl_seen, 1);
        in_valid = 1'b1;
        in_data = 32'h4000_0004;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check({31'h0, in_ready}, 32'h0);
        @(posedge sys_clk);
        #1;
        stall_mode = 2'h1;
        send(32'h4000_0004);
        idle();
        wait_words(3);
        check(got[0], 32'h1000_0001);
        check(got[1], 32'h2000_0002);
        check(got[2], 32'h4000_0004);
        got.delete();
        // One whole vector of flow data, all pulses of a gate together.
        for (g = 0; g < GATES_PER_VECTOR; g++) begin
            for (i = 0; i < PULSES; i++) begin
                seed = lfsr(seed);
                send({4'h3, seed[11:0], seed});
            end
            if (g == 0) begin
                idle();
                check({23'h0, gate_num}, 32'h1);
            end
        end
        idle();
        check({22'h0, beam_num}, 32'h1);
        check({23'h0, gate_num}, 32'h0);
        wait_words(GATES_PER_VECTOR + 2);
        check(got.size(), GATES_PER_VECTOR + 2);
        check(got[0], {4'hE, 10'h001, 18'h0});
        check(got[GATES_PER_VECTOR + 1], {4'hD, 10'h001, 18'h0});
        moving = 0;
        for (i = 1; i <= GATES_PER_VECTOR; i++) begin
            check(got[i], {16'h3000, got[i][15:4], bw_of_vel(got[i][11:4])});
            if (got[i][11:4] != 8'hA5) moving++;
        end
        check({31'h0, moving > 0}, 32'h1);
        check(ctrl_seen, 1);
        // A fixed target cancels to zero; bypass words offered during emission keep their order.
        got.delete();
        for (g = 0; g < GATES_PER_VECTOR; g++) begin
            for (i = 0; i < PULSES; i++) send({4'h3, 28'h0123456});
        end
        idle();
        repeat (520) @(posedge sys_clk);
        #1;
        for (i = 0; i < 4; i++) send({4'(i + 4), 28'h0ABCDEF});
        idle();
        wait_words(GATES_PER_VECTOR + 6);
        check(got.size(), GATES_PER_VECTOR + 6);
        check(got[0], {4'hE, 10'h002, 18'h0});
        check(got[GATES_PER_VECTOR + 5], {4'hD, 10'h002, 18'h0});
        g = 0;
        moving = 0;
        for (i = 1; i < GATES_PER_VECTOR + 5; i++) begin
            if (got[i][31:28] == 4'h3) begin
                check(got[i], 32'h3000_0A50);
                g++;
            end else begin
                check(got[i], {4'(moving + 4), 28'h0ABCDEF});
                moving++;
            end
        end
        check(g, GATES_PER_VECTOR);
        check(moving, 4);
        check({24'h0, lut_addr}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
